// ===== include/bank_map_pkg.sv
package bank_map_pkg;

    // core variant selector
    typedef enum logic [1:0] {
        small_variant_a = 2'h0,
        small_variant_b = 2'h1,
        banked_variant_a = 2'h2,
        banked_variant_b = 2'h3
    } variant_type;

    // reset and fixed values
    localparam logic [7:0] BANK_RESET = 8'h01;
    localparam logic [7:0] COMMON_FIELD = 8'h00;
    localparam logic [7:0] SMALL_FIXED_BANK = 8'h01;
    localparam logic [15:0] PC_STEP_COPY = 16'h0002;

    // register map (byte addresses)
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_PENDING = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h8;
    localparam logic [3:0] OFF_PC = 4'hC;

    // control field positions
    localparam int CTRL_VARIANT_LO = 0;
    localparam int CTRL_MIN_MODE = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // cpu-side request bundle
    typedef struct packed {
        logic [15:0] pc;
        logic fetch;
        logic nb_write;
        logic [7:0] nb_value;
        logic branch_exec;
        logic branch_taken;
        logic pc_copy;
    } cpu_req_type;

    // module state
    typedef struct packed {
        logic [7:0] bank_select_reg;
        logic [7:0] pending_bank_reg;
        logic [23:0] addr;
        logic [15:0] copy_value;
        logic [2:0] ctrl;
        logic aw_seen;
        logic w_seen;
        logic [3:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_type;

endpackage

// ===== src/program_bank_address_mapper.sv
`timescale 1ns/1ps
// How it works
// - program memory lives in lower 8M
// - small variants limit space to 64K
// - program memory is 32K banks 0..255
// - lower logical half always maps bank 0
// - upper logical half maps bank select
// - lowest 256 addresses hold vectors
// - pc bits 0..14 drive lines 0..14
// - lines 15..22 zero or bank select
// - line 23 low on program fetch
// - small variants output pc unchanged
// - bank fixed in small and min modes
// - pc copy stores instruction address plus two
// - pc wrap leaves bank select unchanged
// - reset sets bank select to one
// - software writes only pending bank register
// - taken branch loads pending into select
// - untaken branch copies select into pending
module program_bank_address_mapper (
    input wire logic clk,
    input wire logic rst_n,
    // cpu side
    input wire bank_map_pkg::cpu_req_type cpu_req,
    output logic [23:0] phys_addr,
    output logic [15:0] pc_copy_value,
    // axi4-lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    bank_map_pkg::state_type st; // registered state
    bank_map_pkg::state_type next_st; // next state
    bank_map_pkg::variant_type variant; // decoded variant
    logic min_mode; // minimum mode of banked variants
    logic banking_on; // bank writes allowed
    logic [7:0] area_bank; // bank driven for the upper half
    logic [7:0] nb_sw_value; // software pending value after strobes

    assign variant = bank_map_pkg::variant_type'(st.ctrl[1:0]);
    assign min_mode = st.ctrl[bank_map_pkg::CTRL_MIN_MODE];
    // only banked variants in maximum mode can switch banks
    assign banking_on = variant[1] && !min_mode;

    // handshake outputs
    assign s_axi_awready = !st.aw_seen && !st.bvalid;
    assign s_axi_wready = !st.w_seen && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign phys_addr = st.addr;
    assign pc_copy_value = st.copy_value;

    // upper-half bank: fixed in small variants, else bank select
    always_comb begin
        if (!variant[1]) begin
            // small variants keep bank 1 in the upper half
            area_bank = bank_map_pkg::SMALL_FIXED_BANK;
        end else begin
            // banked variants follow the bank select register
            area_bank = st.bank_select_reg;
        end
    end

    // byte lane 0 carries the pending bank number
    assign nb_sw_value = st.w_strb[0] ? st.w_data[7:0] : st.pending_bank_reg;

    // next-state logic
    always_comb begin
        next_st = st;
        // address generation, registered
        if (!variant[1]) begin
            // sixteen-bit bus: the counter passes as it is
            next_st.addr = {8'h00, cpu_req.pc};
        end else if (cpu_req.pc[15]) begin
            // line 23 low, bank on 15..22, pc top bit dropped
            next_st.addr = {1'b0, area_bank, cpu_req.pc[14:0]};
        end else begin
            // common area: bank 0, vectors in lowest 256 bytes
            next_st.addr = {1'b0, bank_map_pkg::COMMON_FIELD, cpu_req.pc[14:0]};
        end
        // pc copy yields the copy instruction address plus two
        if (cpu_req.pc_copy) begin
            next_st.copy_value = cpu_req.pc + bank_map_pkg::PC_STEP_COPY;
        end
        // bank select changes only on executed branches, never on wrap
        if (cpu_req.branch_exec && banking_on) begin
            if (cpu_req.branch_taken) begin
                // taken: the new bank applies at the branch target
                next_st.bank_select_reg = st.pending_bank_reg;
            end else begin
                // not taken: pending falls back to the live bank
                next_st.pending_bank_reg = st.bank_select_reg;
            end
        end else if (cpu_req.nb_write && banking_on) begin
            // cpu loads pending bank from accumulator or immediate
            next_st.pending_bank_reg = cpu_req.nb_value;
        end
        // axi write channel capture
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_seen = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_seen = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        // perform the write once both halves are held
        if (st.aw_seen && st.w_seen) begin
            next_st.aw_seen = 1'b0;
            next_st.w_seen = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = bank_map_pkg::RESP_OKAY;
            case (st.aw_addr)
                bank_map_pkg::OFF_CTRL: begin
                    // variant and minimum mode sit in lane 0
                    if (st.w_strb[0]) begin
                        next_st.ctrl = st.w_data[2:0];
                    end
                end
                bank_map_pkg::OFF_PENDING: begin
                    // software reaches pending only; cpu traffic wins a tie
                    if (banking_on && !cpu_req.branch_exec && !cpu_req.nb_write) begin
                        next_st.pending_bank_reg = nb_sw_value;
                    end
                end
                bank_map_pkg::OFF_STATUS, bank_map_pkg::OFF_PC: begin
                    next_st.bresp = bank_map_pkg::RESP_OKAY; // read-only, ignored
                end
                default: begin
                    // unmapped offsets answer with an error
                    next_st.bresp = bank_map_pkg::RESP_SLVERR;
                end
            endcase
        end
        // response leaves once the master has taken it
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // axi read
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = bank_map_pkg::RESP_OKAY;
            case (s_axi_araddr)
                bank_map_pkg::OFF_CTRL: begin
                    next_st.rdata = {29'h0000_0000, st.ctrl};
                end
                bank_map_pkg::OFF_PENDING: begin
                    next_st.rdata = {24'h00_0000, st.pending_bank_reg};
                end
                bank_map_pkg::OFF_STATUS: begin
                    next_st.rdata = {24'h00_0000, st.bank_select_reg};
                end
                bank_map_pkg::OFF_PC: begin
                    next_st.rdata = {8'h00, st.addr};
                end
                default: begin
                    // unmapped reads return zero with an error
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = bank_map_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            // read data stands until the master takes it
            next_st.rvalid = 1'b0;
        end
        // synchronous reset overrides every update above
        if (!rst_n) begin
            // bus idle, address zero, control in its reset mode
            next_st = '0;
            next_st.ctrl = bank_map_pkg::CTRL_RESET[2:0];
            // bank 1 fills the upper half after reset
            next_st.bank_select_reg = bank_map_pkg::BANK_RESET;
            // pending mirrors select so a bare branch stays put
            next_st.pending_bank_reg = bank_map_pkg::BANK_RESET;
        end
    end

    // state register: the whole state moves on every rising edge
    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // address path checks
    // upper half carries bank select in banked maximum mode
    chk_bank_area_map: assert property (@(posedge clk) disable iff (!rst_n)
        (variant[1] && cpu_req.pc[15]) |=> (phys_addr[22:15] == $past(st.bank_select_reg)))
        else $error("bank area address wrong");

    // common area drives zeros above line 14
    chk_common_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (variant[1] && !cpu_req.pc[15]) |=> (phys_addr[23:15] == 9'h000))
        else $error("common area not bank 0");

    // low fifteen pc bits pass through
    chk_low_bits: assert property (@(posedge clk) disable iff (!rst_n)
        variant[1] |=> (phys_addr[14:0] == $past(cpu_req.pc[14:0])))
        else $error("low address bits wrong");

    // line 23 never set
    chk_line23_low: assert property (@(posedge clk) disable iff (!rst_n)
        phys_addr[23] == 1'b0)
        else $error("line 23 driven high");

    // small variants pass pc whole
    chk_small_pass: assert property (@(posedge clk) disable iff (!rst_n)
        !variant[1] |=> (phys_addr == {8'h00, $past(cpu_req.pc)}))
        else $error("small variant address wrong");

    // taken branch loads select from pending
    chk_taken_load: assert property (@(posedge clk) disable iff (!rst_n)
        (banking_on && cpu_req.branch_exec && cpu_req.branch_taken)
        |=> (st.bank_select_reg == $past(st.pending_bank_reg)))
        else $error("taken branch did not load bank");

    // untaken branch restores pending
    chk_untaken_copy: assert property (@(posedge clk) disable iff (!rst_n)
        (banking_on && cpu_req.branch_exec && !cpu_req.branch_taken)
        |=> (st.pending_bank_reg == st.bank_select_reg) && $stable(st.bank_select_reg))
        else $error("untaken branch mishandled");

    // select changes only on a taken branch
    chk_select_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !(cpu_req.branch_exec && cpu_req.branch_taken) |=> $stable(st.bank_select_reg))
        else $error("bank select changed without branch");

    // pc copy adds two
    chk_copy_plus2: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_req.pc_copy |=> (pc_copy_value == $past(cpu_req.pc) + 16'h0002))
        else $error("pc copy value wrong");

    // reset puts bank 1 in both registers
    chk_reset_bank: assert property (@(posedge clk)
        !rst_n |=> (st.bank_select_reg == 8'h01) && (st.pending_bank_reg == 8'h01))
        else $error("reset bank wrong");

    // bank register and bus checks
    // cpu load reaches pending when no branch resolves
    chk_pending_cpu_load: assert property (@(posedge clk) disable iff (!rst_n)
        (banking_on && cpu_req.nb_write && !cpu_req.branch_exec)
        |=> (st.pending_bank_reg == $past(cpu_req.nb_value)))
        else $error("pending bank not loaded");

    // software write reaches pending when the cpu is quiet
    chk_pending_sw_write: assert property (@(posedge clk) disable iff (!rst_n)
        (banking_on && st.aw_seen && st.w_seen && st.aw_addr == bank_map_pkg::OFF_PENDING
        && st.w_strb[0] && !cpu_req.branch_exec && !cpu_req.nb_write)
        |=> (st.pending_bank_reg == $past(st.w_data[7:0])))
        else $error("software pending write lost");

    // fixed modes never move bank select
    chk_frozen_bank: assert property (@(posedge clk) disable iff (!rst_n)
        !banking_on |=> $stable(st.bank_select_reg))
        else $error("bank select moved in fixed mode");

    // fixed modes never move pending either
    chk_frozen_pending: assert property (@(posedge clk) disable iff (!rst_n)
        !banking_on |=> $stable(st.pending_bank_reg))
        else $error("pending bank moved in fixed mode");

    // vector page sits at the very bottom of the bus
    chk_vector_page: assert property (@(posedge clk) disable iff (!rst_n)
        (variant[1] && cpu_req.pc[15:8] == 8'h00) |=> (phys_addr[23:8] == 16'h0000))
        else $error("vector fetch off page zero");

    // small variants never reach above 64K
    chk_small_top_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !variant[1] |=> (phys_addr[23:16] == 8'h00))
        else $error("small variant above 64K");

    // counter wrap leaves bank select alone
    chk_wrap_select: assert property (@(posedge clk) disable iff (!rst_n)
        (cpu_req.pc == 16'hFFFF ##1 (cpu_req.pc == 16'h0000
        && !(cpu_req.branch_exec && cpu_req.branch_taken))) |=> $stable(st.bank_select_reg))
        else $error("bank select moved on wrap");

    // copied counter holds between copies
    chk_copy_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !cpu_req.pc_copy |=> $stable(pc_copy_value))
        else $error("pc copy value drifted");

    // control register takes lane 0
    chk_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n)
        (st.aw_seen && st.w_seen && st.aw_addr == bank_map_pkg::OFF_CTRL && st.w_strb[0])
        |=> (st.ctrl == $past(st.w_data[2:0])))
        else $error("control write lost");

    // write response follows both halves
    chk_write_answer: assert property (@(posedge clk) disable iff (!rst_n)
        (st.aw_seen && st.w_seen) |=> s_axi_bvalid)
        else $error("write response missing");

    // write response stands until taken
    chk_bvalid_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped");

    // read answer follows the address
    chk_read_answer: assert property (@(posedge clk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read response missing");

    // read data stands until taken
    chk_rvalid_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("read response dropped");

    // no new write is taken while a response waits
    chk_ready_block: assert property (@(posedge clk) disable iff (!rst_n)
        s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
        else $error("write taken during response");

    // error reads carry zero data
    chk_slverr_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (s_axi_rvalid && s_axi_rresp == bank_map_pkg::RESP_SLVERR) |-> (s_axi_rdata == 32'h0000_0000))
        else $error("error read carries data");

    // status read shows the live bank
    chk_status_mirror: assert property (@(posedge clk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == bank_map_pkg::OFF_STATUS)
        |=> (s_axi_rdata == {24'h00_0000, $past(st.bank_select_reg)}))
        else $error("status read wrong");

    // main scenarios
    cov_bank_switch: cover property (@(posedge clk) disable iff (!rst_n)
        banking_on && cpu_req.branch_exec && cpu_req.branch_taken);
    cov_not_taken: cover property (@(posedge clk) disable iff (!rst_n)
        banking_on && cpu_req.branch_exec && !cpu_req.branch_taken);
    cov_axi_write: cover property (@(posedge clk) disable iff (!rst_n)
        st.bvalid && s_axi_bready);
    cov_pc_wrap: cover property (@(posedge clk) disable iff (!rst_n)
        cpu_req.pc == 16'hFFFF ##1 cpu_req.pc == 16'h0000);
    cov_axi_read: cover property (@(posedge clk) disable iff (!rst_n)
        st.rvalid && s_axi_rready);

endmodule

// ===== verif/prog_mem_model.sv
`timescale 1ns/1ps
// program memory hanging on the physical address bus
module prog_mem_model (
    input wire logic clk,
    input wire logic [23:0] addr,
    output logic [7:0] data,
    output logic data_region_hit
);
    // top line set means the fetch strayed out of program memory
    assign data_region_hit = addr[23];
    // byte answered one cycle later, a pattern that differs per address
    always_ff @(posedge clk) begin
        data <= addr[7:0] ^ addr[15:8] ^ ~addr[22:15];
    end
endmodule

// ===== verif/program_bank_address_mapper_bench.sv
`timescale 1ns/1ps
module program_bank_address_mapper_bench;
    logic clk, rst_n, hit; // clock, reset, stray fetch flag
    bank_map_pkg::cpu_req_type cpu_req; // cpu-side request
    logic [23:0] phys_addr; // address bus
    logic [15:0] pc_copy_value; // copied counter
    logic [7:0] mem_data; // byte from program memory
    logic [3:0] awaddr, araddr, wstrb; // axi addresses and strobes
    logic [31:0] wdata, rdata; // axi data
    logic [1:0] bresp, rresp; // axi responses
    logic awvalid, awready, wvalid, wready, bvalid, bready; // write handshakes
    logic arvalid, arready, rvalid, rready; // read handshakes
    int bad_count, checked; // mismatch and comparison counts
    program_bank_address_mapper program_bank_address_mapper_inst (
        .clk(clk), .rst_n(rst_n), .cpu_req(cpu_req), .phys_addr(phys_addr),
        .pc_copy_value(pc_copy_value), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    prog_mem_model prog_mem_model_inst (
        .clk(clk), .addr(phys_addr), .data(mem_data), .data_region_hit(hit));
    // clock at 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // verdict and end of run
    task automatic test_done();
        $display("compared %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one comparison
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    // register write, waits for the response
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        logic aw_hit, w_hit, b_hit;
        logic [1:0] resp;
        b_hit = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !b_hit; n++) begin
            @(negedge clk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid;
            resp = bresp;
            @(posedge clk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            if (b_hit) bready <= 1'b0;
        end
        if (!b_hit) begin
            bad_count++;
            test_done();
        end else begin
            chk("bresp", {30'h0, bank_map_pkg::RESP_OKAY}, {30'h0, resp});
        end
    endtask
    // register read compared against expectation
    task automatic axi_read(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ar_hit, r_hit;
        logic [31:0] d;
        logic [1:0] resp;
        r_hit = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !r_hit; n++) begin
            @(negedge clk);
            ar_hit = arvalid && arready;
            r_hit = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge clk);
            if (ar_hit) arvalid <= 1'b0;
            if (r_hit) rready <= 1'b0;
        end
        if (!r_hit) begin
            bad_count++;
            test_done();
        end else begin
            chk("rdata", exp, d);
            chk("rresp", {30'h0, er}, {30'h0, resp});
        end
    endtask
    // one-cycle bank load and/or branch pulse
    task automatic cpu_op(input logic nbw, input logic [7:0] v, input logic br, input logic tk);
        @(posedge clk);
        cpu_req.nb_write <= nbw;
        cpu_req.nb_value <= v;
        cpu_req.branch_exec <= br;
        cpu_req.branch_taken <= tk;
        @(posedge clk);
        cpu_req.nb_write <= 1'b0;
        cpu_req.branch_exec <= 1'b0;
    endtask
    // present a counter value and judge the bus address a cycle later
    task automatic fetch_at(input logic [15:0] pc, input logic [23:0] exp);
        @(posedge clk);
        cpu_req.pc <= pc;
        @(posedge clk);
        #1;
        chk("phys_addr", {8'h00, exp}, {8'h00, phys_addr});
        chk("data_region_hit", 32'h0, {31'h0, hit});
        // memory answers the held address one edge later
        @(posedge clk);
        #1;
        chk("mem_data", {24'h0, exp[7:0] ^ exp[15:8] ^ ~exp[22:15]}, {24'h0, mem_data});
    endtask
    // reset state of bank registers
    task automatic reset_values();
        axi_read(bank_map_pkg::OFF_CTRL, bank_map_pkg::CTRL_RESET, 2'h0);
        axi_read(bank_map_pkg::OFF_STATUS, 32'h01, 2'h0);
        axi_read(bank_map_pkg::OFF_PENDING, 32'h01, 2'h0);
        fetch_at(16'h8000, 24'h008000);
    endtask
    // common half and bank half placement
    task automatic halves();
        fetch_at(16'h00FF, 24'h0000FF);
        fetch_at(16'h7FFF, 24'h007FFF);
        fetch_at(16'hFFFF, 24'h00FFFF);
    endtask
    // bank only changes on a taken branch, not on the load
    task automatic taken_then_not();
        cpu_op(1'b1, 8'h05, 1'b0, 1'b0);
        fetch_at(16'h8123, 24'h008123);
        axi_read(bank_map_pkg::OFF_PENDING, 32'h05, 2'h0);
        cpu_op(1'b0, 8'h00, 1'b1, 1'b1);
        fetch_at(16'h8123, 24'h028123);
        cpu_op(1'b1, 8'h09, 1'b0, 1'b0);
        cpu_op(1'b0, 8'h00, 1'b1, 1'b0);
        axi_read(bank_map_pkg::OFF_STATUS, 32'h05, 2'h0);
        axi_read(bank_map_pkg::OFF_PENDING, 32'h05, 2'h0);
    endtask
    // highest bank via the register bus, then wrap to the common area
    task automatic top_bank_wrap();
        axi_write(bank_map_pkg::OFF_PENDING, 32'hFF);
        cpu_op(1'b0, 8'h00, 1'b1, 1'b1);
        fetch_at(16'hFFFF, 24'h7FFFFF);
        fetch_at(16'h0000, 24'h000000);
        axi_read(bank_map_pkg::OFF_STATUS, 32'hFF, 2'h0);
        axi_read(4'h1, 32'h0, bank_map_pkg::RESP_SLVERR);
    endtask
    // counter copy holds instruction address plus two
    task automatic copy_pc();
        @(posedge clk);
        cpu_req.pc <= 16'h0100;
        cpu_req.pc_copy <= 1'b1;
        @(posedge clk);
        cpu_req.pc_copy <= 1'b0;
        #1;
        chk("pc_copy_value", 32'h0102, {16'h0, pc_copy_value});
    endtask
    // small variants, minimum mode and the second banked variant
    task automatic variants();
        for (int v = 0; v < 2; v++) begin
            axi_write(bank_map_pkg::OFF_CTRL, v);
            cpu_op(1'b1, 8'h07, 1'b1, 1'b1);
            fetch_at(16'hFFFF, 24'h00FFFF);
        end
        axi_write(bank_map_pkg::OFF_CTRL, 32'h6);
        cpu_op(1'b1, 8'h07, 1'b1, 1'b1);
        fetch_at(16'hFFFF, 24'h7FFFFF);
        axi_write(bank_map_pkg::OFF_CTRL, 32'h3);
        cpu_op(1'b1, 8'h07, 1'b0, 1'b0);
        cpu_op(1'b0, 8'h00, 1'b1, 1'b1);
        fetch_at(16'h8000, 24'h038000);
    endtask
    // reset, scenarios, verdict
    initial begin
        bad_count = 0;
        checked = 0;
        rst_n = 1'b0;
        cpu_req = '0;
        cpu_req.fetch = 1'b1;
        {awaddr, araddr, wstrb, wdata} = {12'h00F, 32'h0};
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        reset_values();
        halves();
        taken_then_not();
        top_bank_wrap();
        copy_pc();
        variants();
        test_done();
    end
endmodule
